// [hsp_params.svh]
/*
 * Constants of the high-voltage serial programming port: frame layout,
 * instruction and command codes, output idle level, fifo sizing.
 * Assumes inclusion by the package and by design files only.
 */
`ifndef HSP_PARAMS_SVH
`define HSP_PARAMS_SVH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define HSP_FRAME_BITS   4'hB
`define HSP_FRAME_LAST   4'hA
`define HSP_ENTRY_CODE   3'h0
`define HSP_CLK_MIN_NS   220
`define HSP_SYS_CLK_NS   25

// ----------------------------------------------------------------------
// instruction codes on the instruction input
// ----------------------------------------------------------------------
`define HSP_I_LOAD_CMD   8'h4C
`define HSP_I_ADDR_LO    8'h0C
`define HSP_I_ADDR_HI    8'h1C
`define HSP_I_DATA_LO    8'h2C
`define HSP_I_DATA_HI    8'h3C
`define HSP_I_LATCH_FL   8'h7D
`define HSP_I_LATCH_EE   8'h6D
`define HSP_I_ARM        8'h64
`define HSP_I_EXEC       8'h6C
`define HSP_I_RD_LO      8'h68
`define HSP_I_RD_HI      8'h78

// ----------------------------------------------------------------------
// command codes on the data input with the command-load instruction
// ----------------------------------------------------------------------
`define HSP_C_NOP        8'h00
`define HSP_C_ERASE      8'h80
`define HSP_C_WR_FLASH   8'h10
`define HSP_C_RD_FLASH   8'h02
`define HSP_C_WR_EEP     8'h11
`define HSP_C_RD_EEP     8'h03
`define HSP_C_RD_SIG     8'h08

// ----------------------------------------------------------------------
// misc
// ----------------------------------------------------------------------
`define HSP_TX_IDLE      8'hFF
`define HSP_FIFO_DEPTH   32
`endif

// [hsp_pkg.sv]
/*
 * Types shared by the programming port modules.
 * Assumes hsp_params.svh is reachable on the include path.
 */
package hsp_pkg;
`include "hsp_params.svh"

   typedef enum logic [2:0] {
      HSP_OP_ERASE_FLASH, HSP_OP_ERASE_EEP, HSP_OP_ERASE_LOCK,
      HSP_OP_WR_FLASH, HSP_OP_WR_EEP,
      HSP_OP_RD_FLASH, HSP_OP_RD_EEP, HSP_OP_RD_SIG
   } hsp_op_t;

   typedef struct packed {
      logic        valid;
      hsp_op_t     op;
      logic [15:0] addr;
      logic [15:0] wdata;
   } hsp_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic [7:0] instr;
   } hsp_frame_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] data;
   } hsp_entry_t;
endpackage : hsp_pkg

// [hsp_fifo.sv]
/*
 * Page buffer fifo, width and depth parameters, valid/ready both sides.
 * Assumes both sides run on the same clock.
 */
`timescale 1ns/10ps
module hsp_fifo #(
   parameter int W = 24,
   parameter int D = 32
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_flush,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } hsp_fifo_st_t;

   hsp_fifo_st_t q, d;
   logic [W-1:0] mem [D];
   logic         push;
   logic         pop;

   assign o_out_valid = (q.wp != q.rp);
   assign o_in_ready  = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
   assign o_out_data  = mem[q.rp[AW-1:0]];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_comb begin
      d = q;
      if (push) begin
         d.wp = q.wp + 1'b1;
      end
      if (pop) begin
         d.rp = q.rp + 1'b1;
      end
      if (i_flush) begin
         d = '0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem[q.wp[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : hsp_fifo

// [hsp_frame_rx.sv]
/*
 * Pin synchroniser and frame receiver for the serial programming link.
 * Assumes the link clock is far slower than the system clock.
 */
`timescale 1ns/10ps
module hsp_frame_rx (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_hv_reset,
   input  wire logic         i_hv_serial_clock_in,
   input  wire logic         i_hv_serial_data_in,
   input  wire logic         i_hv_serial_instr_in,
   input  wire logic         i_hv_serial_data_out,
   output logic              o_hv,
   output logic [2:0]        o_pattern,
   output logic              o_rise,
   output hsp_pkg::hsp_frame_t o_frame
);
   import hsp_pkg::*;

   typedef struct packed {
      logic [4:0]  s1;
      logic [4:0]  s2;
      logic        clk_prev;
      logic [3:0]  cnt;
      logic [10:0] sr_d;
      logic [10:0] sr_i;
      hsp_frame_t  frame;
   } hsp_rx_st_t;

   hsp_rx_st_t q, d;
   logic       rise;

   // s1 feeds s2 only
   assign rise      = q.s2[0] && !q.clk_prev;
   assign o_hv      = q.s2[4];
   assign o_pattern = q.s2[3:1];
   assign o_rise    = rise;
   assign o_frame   = q.frame;

   always_comb begin
      d          = q;
      d.s1       = {i_hv_reset, i_hv_serial_data_out, i_hv_serial_instr_in,
                    i_hv_serial_data_in, i_hv_serial_clock_in};
      d.s2       = q.s1;
      d.clk_prev = q.s2[0];
      d.frame.valid = 1'b0;
      if (!q.s2[4]) begin
         d.cnt = '0;
      end else if (rise) begin
         d.sr_d = {q.sr_d[9:0], q.s2[1]};
         d.sr_i = {q.sr_i[9:0], q.s2[2]};
         if (q.cnt == `HSP_FRAME_LAST) begin
            d.cnt         = '0;
            d.frame.valid = 1'b1;
            d.frame.data  = q.sr_d[8:1];
            d.frame.instr = q.sr_i[8:1];
         end else begin
            d.cnt = q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : hsp_frame_rx

// [hsp_prog_port.sv]
/*
 * Target side of the high-voltage serial programming port: mode entry,
 * instruction decoding, page buffer, erase/program/read sequencing.
 * Assumes a nonvolatile memory controller on the system clock that holds
 * i_nvm_ack high one cycle per finished request and returns read data
 * with that ack, well before the next link clock edge.
 */
// Overview of operation
// - mode entered when data, instruction, output pins read zero at high voltage.
// - mode ends at power down or reset pin back to 0 V.
// - last command and address are kept across operations.
// - erase clears flash, eeprom, then lock bits; fuses untouched.
// - preserve fuse keeps eeprom through chip erase.
// - data output low after third erase instruction, high when done.
// - flash data gathered in a page buffer, page written in one go.
// - flash write: command once, fill buffer, high address, program, poll.
// - eeprom page completion shown by data output rising after second instruction.
// - all serial bits move on the rising programming clock edge.
// - flash read sequences shift addressed low and high bytes out.
// - eeprom read sequence shifts addressed byte out.
// - write-flash command code 0x10 with command-load instruction.
// - read-flash command code 0x02 with command-load instruction.
// - write-eeprom command code 0x11 with command-load instruction.
`timescale 1ns/10ps
module hsp_prog_port #(
   parameter int FIFO_DEPTH = `HSP_FIFO_DEPTH
) (
   input  wire logic            i_sys_clk,
   input  wire logic            i_rst_n,
   input  wire logic            i_hv_reset,
   input  wire logic            i_hv_serial_clock_in,
   input  wire logic            i_hv_serial_data_in,
   input  wire logic            i_hv_serial_instr_in,
   input  wire logic            i_hv_serial_data_out,
   output logic                 o_hv_serial_data_out,
   output logic                 o_hv_serial_data_out_oe,
   output logic                 o_prog_mode,
   input  wire logic            i_eeprom_preserve_fuse,
   output hsp_pkg::hsp_req_t    o_nvm_req,
   input  wire logic            i_nvm_ack,
   input  wire logic [15:0]     i_nvm_rdata
);
   import hsp_pkg::*;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF, ST_IDLE, ST_PUSH, ST_ERASE, ST_PROG, ST_READ
   } hsp_st_t;

   typedef struct packed {
      hsp_st_t    st;
      logic       hv_prev;
      logic       mode;
      logic [7:0] cmd;
      logic [7:0] a_hi;
      logic [7:0] a_lo;
      logic [7:0] d_lo;
      logic [7:0] d_hi;
      logic       armed;
      logic       hi_sel;
      logic       issued;
      logic [1:0] step;
      logic [7:0] tx;
      hsp_entry_t pend;
      hsp_req_t   req;
      logic       txb;
      logic       txb_oe;
   } hsp_port_st_t;

   hsp_port_st_t q, d;

   logic       hv;
   logic [2:0] pattern;
   logic       rise;
   hsp_frame_t frame;
   logic       buf_in_ready;
   logic       buf_out_valid;
   logic       buf_out_ready;
   hsp_entry_t buf_out;
   logic       buf_flush;

   // ----------------------------------------------------------------------
   // link receiver and page buffer
   // ----------------------------------------------------------------------
   hsp_frame_rx u_rx (
      .i_sys_clk            (i_sys_clk),
      .i_rst_n              (i_rst_n),
      .i_hv_reset           (i_hv_reset),
      .i_hv_serial_clock_in (i_hv_serial_clock_in),
      .i_hv_serial_data_in  (i_hv_serial_data_in),
      .i_hv_serial_instr_in (i_hv_serial_instr_in),
      .i_hv_serial_data_out (i_hv_serial_data_out),
      .o_hv                 (hv),
      .o_pattern            (pattern),
      .o_rise               (rise),
      .o_frame              (frame)
   );

   // page buffer drained by the program step, flushed outside mode; stalls on nvm acks
   hsp_fifo #(
      .W ($bits(hsp_entry_t)),
      .D (FIFO_DEPTH)
   ) u_page_buf (
      .i_sys_clk   (i_sys_clk),
      .i_rst_n     (i_rst_n),
      .i_flush     (buf_flush),
      .i_in_valid  (q.st == ST_PUSH),
      .o_in_ready  (buf_in_ready),
      .i_in_data   (q.pend),
      .o_out_valid (buf_out_valid),
      .i_out_ready (buf_out_ready),
      .o_out_data  (buf_out)
   );

   assign buf_out_ready = (q.st == ST_PROG) && !q.req.valid;
   assign buf_flush     = !q.mode;

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign o_hv_serial_data_out    = q.txb;
   assign o_hv_serial_data_out_oe = q.txb_oe;
   assign o_prog_mode             = q.mode;
   assign o_nvm_req               = q.req;

   // ----------------------------------------------------------------------
   // sequencing
   // ----------------------------------------------------------------------
   always_comb begin
      d         = q;
      d.hv_prev = hv;
      if (q.req.valid && i_nvm_ack) begin
         d.req.valid = 1'b0;
      end

      // output bits advance on the same edges that shift the inputs in
      if (rise && q.mode) begin
         d.tx = {q.tx[6:0], 1'b1};
      end

      case (q.st)
         ST_OFF: begin
            if (hv && !q.hv_prev) begin
               // pattern sampled as high voltage is seen; pins must
               // already be stable, the programmer holds them on
               d.mode = (pattern == `HSP_ENTRY_CODE);
               d.st   = d.mode ? ST_IDLE : ST_OFF;
               d.tx   = `HSP_TX_IDLE;
               d.cmd  = `HSP_C_NOP;
            end
         end

         ST_IDLE: begin
            if (frame.valid) begin
               d.armed = (frame.instr == `HSP_I_ARM);
               case (frame.instr)
                  `HSP_I_LOAD_CMD: d.cmd  = frame.data;
                  `HSP_I_ADDR_LO:  d.a_lo = frame.data;
                  `HSP_I_ADDR_HI:  d.a_hi = frame.data;
                  `HSP_I_DATA_LO:  d.d_lo = frame.data;
                  `HSP_I_DATA_HI:  d.d_hi = frame.data;
                  `HSP_I_LATCH_FL: begin
                     if (q.cmd == `HSP_C_WR_FLASH) begin
                        d.pend = '{addr: q.a_lo, data: {q.d_hi, q.d_lo}};
                        d.st   = ST_PUSH;
                     end
                  end
                  `HSP_I_LATCH_EE: begin
                     if (q.cmd == `HSP_C_WR_EEP) begin
                        d.pend = '{addr: q.a_lo, data: {8'h00, q.d_lo}};
                        d.st   = ST_PUSH;
                     end
                  end
                  `HSP_I_EXEC: begin
                     if (q.armed) begin
                        case (q.cmd)
                           `HSP_C_ERASE: begin
                              d.st   = ST_ERASE;
                              d.step = 2'h0;
                           end
                           `HSP_C_WR_FLASH, `HSP_C_WR_EEP: begin
                              d.st = ST_PROG;
                           end
                           default: begin
                              d.st = ST_IDLE;
                           end
                        endcase
                     end
                  end
                  `HSP_I_RD_LO, `HSP_I_RD_HI: begin
                     if (q.cmd == `HSP_C_RD_FLASH || q.cmd == `HSP_C_RD_EEP ||
                         q.cmd == `HSP_C_RD_SIG) begin
                        d.hi_sel = (frame.instr == `HSP_I_RD_HI);
                        d.issued = 1'b0;
                        d.st     = ST_READ;
                     end
                  end
                  default: begin
                     d.st = ST_IDLE;
                  end
               endcase
            end
         end

         // waits here while the buffer is full instead of losing the word
         ST_PUSH: begin
            if (buf_in_ready) begin
               d.st = ST_IDLE;
            end
         end

         // next step only once the previous request is acknowledged, so
         // lock bits clear after the flash erase has fully finished
         ST_ERASE: begin
            if (!q.req.valid) begin
               case (q.step)
                  2'h0: begin
                     d.req  = '{valid: 1'b1, op: HSP_OP_ERASE_FLASH, addr: '0, wdata: '0};
                     d.step = 2'h1;
                  end
                  2'h1: begin
                     if (!i_eeprom_preserve_fuse) begin
                        d.req = '{valid: 1'b1, op: HSP_OP_ERASE_EEP, addr: '0, wdata: '0};
                     end
                     d.step = 2'h2;
                  end
                  2'h2: begin
                     d.req  = '{valid: 1'b1, op: HSP_OP_ERASE_LOCK, addr: '0, wdata: '0};
                     d.step = 2'h3;
                  end
                  default: begin
                     d.st = ST_IDLE;
                     d.tx = `HSP_TX_IDLE;
                  end
               endcase
            end
         end

         ST_PROG: begin
            if (!q.req.valid) begin
               if (buf_out_valid) begin
                  d.req.valid = 1'b1;
                  d.req.op    = (q.cmd == `HSP_C_WR_FLASH) ? HSP_OP_WR_FLASH : HSP_OP_WR_EEP;
                  d.req.addr  = {q.a_hi, buf_out.addr};
                  d.req.wdata = buf_out.data;
               end else begin
                  d.st = ST_IDLE;
                  d.tx = `HSP_TX_IDLE;
               end
            end
         end

         ST_READ: begin
            if (!q.issued) begin
               d.issued    = 1'b1;
               d.req.valid = 1'b1;
               d.req.wdata = '0;
               d.req.addr  = {q.a_hi, q.a_lo};
               case (q.cmd)
                  `HSP_C_RD_FLASH: d.req.op = HSP_OP_RD_FLASH;
                  `HSP_C_RD_EEP:   d.req.op = HSP_OP_RD_EEP;
                  default:         d.req.op = HSP_OP_RD_SIG;
               endcase
            end else if (i_nvm_ack) begin
               d.issued = 1'b0;
               d.tx     = q.hi_sel ? i_nvm_rdata[15:8] : i_nvm_rdata[7:0];
               d.st     = ST_IDLE;
            end
         end

         default: begin
            d.st = ST_OFF;
         end
      endcase

      // leaving high voltage drops the mode whatever is in flight
      if (!hv) begin
         d.st     = ST_OFF;
         d.mode   = 1'b0;
         d.armed  = 1'b0;
         d.issued = 1'b0;
         d.req    = '0;
      end

      // pin is driven only in mode; low while busy
      d.txb_oe = d.mode;
      d.txb    = (d.st == ST_ERASE || d.st == ST_PROG) ? 1'b0 : d.tx[7];
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         q    <= '0;
         q.st <= ST_OFF;
         q.tx <= `HSP_TX_IDLE;
      end else begin
         q <= d;
      end
   end
endmodule : hsp_prog_port

// [hsp_prog_port_monitor.sv]
/*
 * Port-level checker of the programming port.
 * Assumes binding onto hsp_prog_port and a memory side that acks once per request.
 */
`timescale 1ns/10ps
module hsp_prog_port_monitor #(
   parameter int FIFO_DEPTH = 32
) (
   input wire logic              i_sys_clk,
   input wire logic              i_rst_n,
   input wire logic              i_hv_reset,
   input wire logic              i_hv_serial_clock_in,
   input wire logic              i_hv_serial_data_in,
   input wire logic              i_hv_serial_instr_in,
   input wire logic              i_hv_serial_data_out,
   input wire logic              o_hv_serial_data_out,
   input wire logic              o_hv_serial_data_out_oe,
   input wire logic              o_prog_mode,
   input wire logic              i_eeprom_preserve_fuse,
   input wire hsp_pkg::hsp_req_t o_nvm_req,
   input wire logic              i_nvm_ack,
   input wire logic [15:0]       i_nvm_rdata
);
   import hsp_pkg::*;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   // lock erase must wait for a finished flash erase
   logic fl_done_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) fl_done_q <= 1'b0;
      else if (i_nvm_ack && o_nvm_req.valid && o_nvm_req.op == HSP_OP_ERASE_FLASH) fl_done_q <= 1'b1;
      else if (i_nvm_ack && o_nvm_req.valid && o_nvm_req.op == HSP_OP_ERASE_LOCK) fl_done_q <= 1'b0;
   end
   a_oe_follows_mode: assert property (o_hv_serial_data_out_oe == o_prog_mode)
      else $error("output enable differs from mode");
   a_exit_on_low: assert property ($fell(i_hv_reset) |-> ##[1:6] !o_prog_mode)
      else $error("mode kept after high voltage removed");
   a_entry_needs_hv: assert property ($rose(o_prog_mode) |-> i_hv_reset)
      else $error("mode entered without high voltage");
   a_idle_no_req: assert property (!o_prog_mode |-> !o_nvm_req.valid)
      else $error("memory request outside mode");
   a_req_held: assert property (o_nvm_req.valid && !i_nvm_ack |=> o_nvm_req.valid && $stable(o_nvm_req))
      else $error("request changed before ack");
   a_busy_low: assert property (o_nvm_req.valid && o_nvm_req.op < HSP_OP_RD_FLASH
      |-> !o_hv_serial_data_out)
      else $error("data out high while busy");
   a_fuse_keeps: assert property (o_nvm_req.valid && i_eeprom_preserve_fuse
      |-> o_nvm_req.op != HSP_OP_ERASE_EEP)
      else $error("eeprom erased with preserve fuse");
   a_lock_last: assert property (o_nvm_req.valid && o_nvm_req.op == HSP_OP_ERASE_LOCK |-> fl_done_q)
      else $error("lock erased before flash erase");
endmodule : hsp_prog_port_monitor

bind hsp_prog_port hsp_prog_port_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_hsp_prog_port_monitor (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_hv_reset(i_hv_reset),
   .i_hv_serial_clock_in(i_hv_serial_clock_in), .i_hv_serial_data_in(i_hv_serial_data_in),
   .i_hv_serial_instr_in(i_hv_serial_instr_in), .i_hv_serial_data_out(i_hv_serial_data_out),
   .o_hv_serial_data_out(o_hv_serial_data_out), .o_hv_serial_data_out_oe(o_hv_serial_data_out_oe),
   .o_prog_mode(o_prog_mode), .i_eeprom_preserve_fuse(i_eeprom_preserve_fuse),
   .o_nvm_req(o_nvm_req), .i_nvm_ack(i_nvm_ack), .i_nvm_rdata(i_nvm_rdata));

// [hsp_programmer.sv]
/*
 * Behavioural high-voltage serial programmer.
 * Assumes the system clock for pacing; link clock stands low between frames.
 */
`timescale 1ns/10ps
module hsp_programmer (
   input  wire logic i_sys_clk,
   input  wire logic i_out_pin,
   output logic      o_hv,
   output logic      o_lck,
   output logic      o_din,
   output logic      o_ins,
   output logic      o_ent,
   output logic      o_ent_oe
);
   initial begin
      {o_hv, o_lck, o_din, o_ins, o_ent, o_ent_oe} = 6'h00;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask : cyc
   // pat is {data out, instr in, data in}
   task automatic enter(input logic [2:0] pat);
      {o_ent, o_ins, o_din} = pat;
      o_ent_oe = 1'b1;
      cyc(4);
      o_hv = 1'b1;
      cyc(400);
      o_ent_oe = 1'b0;
      {o_ins, o_din} = 2'h0;
      cyc(12000);
   endtask : enter
   task automatic leave();
      o_hv = 1'b0;
      cyc(20);
   endtask : leave
   task automatic frame(input logic [7:0] d, input logic [7:0] i, output logic [7:0] q);
      logic [10:0] fd;
      logic [10:0] fi;
      logic [10:0] fo;
      fd = {1'b0, d, 2'h0};
      fi = {1'b0, i, 2'h0};
      for (int b = 10; b >= 0; b--) begin
         o_din = fd[b];
         o_ins = fi[b];
         cyc(4);
         o_lck = 1'b1;
         fo[b] = i_out_pin;
         cyc(4);
         o_lck = 1'b0;
      end
      cyc(16);
      q = fo[10:3];
   endtask : frame
endmodule : hsp_programmer

// [test_hsp_prog_port.sv]
/*
 * Self-checking bench of the programming port.
 * Assumes the programmer model and a simple memory responder here.
 */
`timescale 1ns/10ps
module test_hsp_prog_port;
   import hsp_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, fuse = 1'b0, ack = 1'b0, pin_last = 1'b0;
   logic        hv, lck, din, ins, p_ent, p_oe, txb, txb_oe, mode, pin;
   logic [15:0] rdata = 16'h0000;
   logic [15:0] fl [256];
   logic [15:0] ee [256];
   hsp_req_t    req;
   hsp_req_t    log_q[$];
   int          cnt = 0, cycles = 0, miscompares = 0, comparisons = 0;
   logic [7:0]  q;
   always #12.5 clk = ~clk;
   // released pin toggles every cycle, starting from the inverse of the last driven level
   assign pin = txb_oe ? txb : (p_oe ? p_ent : ~pin_last);
   always @(posedge clk) pin_last <= pin;
   hsp_programmer u_hsp_programmer (.i_sys_clk(clk), .i_out_pin(pin), .o_hv(hv), .o_lck(lck),
      .o_din(din), .o_ins(ins), .o_ent(p_ent), .o_ent_oe(p_oe));
   hsp_prog_port #(.FIFO_DEPTH(32)) u_hsp_prog_port (.i_sys_clk(clk), .i_rst_n(rst_n),
      .i_hv_reset(hv), .i_hv_serial_clock_in(lck), .i_hv_serial_data_in(din),
      .i_hv_serial_instr_in(ins), .i_hv_serial_data_out(pin), .o_hv_serial_data_out(txb),
      .o_hv_serial_data_out_oe(txb_oe), .o_prog_mode(mode), .i_eeprom_preserve_fuse(fuse),
      .o_nvm_req(req), .i_nvm_ack(ack), .i_nvm_rdata(rdata));
   // memory responder: reads answer fast, erase and program take long
   always @(posedge clk) begin
      ack <= 1'b0;
      if (req.valid === 1'b1 && !ack) begin
         cnt <= cnt + 1;
         if (cnt == ((req.op >= HSP_OP_RD_FLASH) ? 1 : 20)) begin
            cnt <= 0;
            ack <= 1'b1;
            log_q.push_back(req);
            case (req.op)
               HSP_OP_ERASE_FLASH: foreach (fl[k]) fl[k] <= 16'hFFFF;
               HSP_OP_ERASE_EEP:   foreach (ee[k]) ee[k] <= 16'hFFFF;
               HSP_OP_WR_FLASH:    fl[req.addr[7:0]] <= req.wdata;
               HSP_OP_WR_EEP:      ee[req.addr[7:0]] <= req.wdata;
               default: ;
            endcase
            rdata <= (req.op == HSP_OP_RD_EEP) ? ee[req.addr[7:0]] : fl[req.addr[7:0]];
         end
      end
   end
   task automatic test_done();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : test_done
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         miscompares++;
         test_done();
      end
   end
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, seen);
         miscompares++;
      end
   endtask : chk
   task automatic f(input logic [7:0] d, input logic [7:0] i);
      logic [7:0] x;
      u_hsp_programmer.frame(d, i, x);
   endtask : f
   task automatic wait_ready();
      for (int n = 0; n < 400 && pin !== 1'b1; n++) @(negedge clk);
      chk("ready", pin, 16'h0001);
   endtask : wait_ready
   task automatic t_entry();
      u_hsp_programmer.enter(3'h2);
      chk("bad_entry_mode", mode, 16'h0000);
      u_hsp_programmer.leave();
      u_hsp_programmer.enter(3'h0);
      chk("entry_mode", mode, 16'h0001);
      chk("entry_oe", txb_oe, 16'h0001);
      $display("test entry ended");
   endtask : t_entry
   task automatic t_erase();
      for (int k = 1; k >= 0; k--) begin
         fuse = k[0];
         log_q.delete();
         f(8'h80, 8'h4C);
         f(8'h00, 8'h64);
         f(8'h00, 8'h6C);
         chk("erase_busy", pin, 16'h0000);
         wait_ready();
         chk("erase_count", 16'(log_q.size()), 16'(3 - k));
         chk("erase_first", 16'(log_q[0].op), 16'(HSP_OP_ERASE_FLASH));
         chk("erase_last", 16'(log_q[2 - k].op), 16'(HSP_OP_ERASE_LOCK));
         if (k == 0) chk("erase_eep", 16'(log_q[1].op), 16'(HSP_OP_ERASE_EEP));
         f(8'h00, 8'h4C);
      end
      fuse = 1'b0;
      $display("test erase ended");
   endtask : t_erase
   task automatic t_flash();
      log_q.delete();
      f(8'h10, 8'h4C);
      for (int w = 0; w < 2; w++) begin
         f(8'h05 + 8'(w), 8'h0C);
         f(8'h50 + 8'(w), 8'h2C);
         f(8'hA0 + 8'(w), 8'h3C);
         f(8'h00, 8'h7D);
      end
      chk("buffered", 16'(log_q.size()), 16'h0000);
      f(8'h01, 8'h1C);
      f(8'h00, 8'h64);
      f(8'h00, 8'h6C);
      wait_ready();
      chk("wr_count", 16'(log_q.size()), 16'h0002);
      for (int w = 0; w < 2; w++) begin
         chk("wr_op", 16'(log_q[w].op), 16'(HSP_OP_WR_FLASH));
         chk("wr_addr", log_q[w].addr, 16'h0105 + 16'(w));
         chk("wr_data", log_q[w].wdata, 16'hA050 + 16'(w * 16'h0101));
      end
      f(8'h00, 8'h4C);
      f(8'h02, 8'h4C);
      f(8'h01, 8'h1C);
      for (int w = 0; w < 2; w++) begin
         f(8'h05 + 8'(w), 8'h0C);
         f(8'h00, 8'h68);
         u_hsp_programmer.frame(8'h00, 8'h6C, q);
         chk("rd_lo", {8'h00, q}, 16'h0050 + 16'(w));
         f(8'h00, 8'h78);
         u_hsp_programmer.frame(8'h00, 8'h7C, q);
         chk("rd_hi", {8'h00, q}, 16'h00A0 + 16'(w));
      end
      $display("test flash ended");
   endtask : t_flash
   task automatic t_eeprom();
      log_q.delete();
      f(8'h11, 8'h4C);
      f(8'h07, 8'h0C);
      f(8'h00, 8'h1C);
      f(8'h9E, 8'h2C);
      f(8'h00, 8'h6D);
      f(8'h00, 8'h64);
      f(8'h00, 8'h6C);
      chk("ee_busy", pin, 16'h0000);
      wait_ready();
      chk("ee_op", 16'(log_q[0].op), 16'(HSP_OP_WR_EEP));
      chk("ee_data", {8'h00, log_q[0].wdata[7:0]}, 16'h009E);
      f(8'h03, 8'h4C);
      f(8'h07, 8'h0C);
      f(8'h00, 8'h68);
      u_hsp_programmer.frame(8'h00, 8'h6C, q);
      chk("ee_read", {8'h00, q}, 16'h009E);
      f(8'h08, 8'h4C);
      f(8'h00, 8'h68);
      chk("sig_op", 16'(log_q[$].op), 16'(HSP_OP_RD_SIG));
      u_hsp_programmer.leave();
      chk("exit_mode", mode, 16'h0000);
      chk("exit_oe", txb_oe, 16'h0000);
      $display("test eeprom ended");
   endtask : t_eeprom
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_entry();
      t_erase();
      t_flash();
      t_eeprom();
      test_done();
   end
endmodule : test_hsp_prog_port
